/* File: src/cpr_io_offset.sv */
// One I/O window offset register pair, low and high byte
module cpr_io_offset (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Write side
	input wire logic clear,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [cpr_pkg::DATA_W-1:0] wdata,
	// Stored offset
	output logic [cpr_pkg::OFFSET_W-1:0] offset
);

	logic [cpr_pkg::DATA_W-1:0] lo_r;
	logic [cpr_pkg::DATA_W-1:0] hi_r;

	// Removal reset wins over a write in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lo_r <= cpr_pkg::OFFSET_RESET;
		end else if (clear) begin
			lo_r <= cpr_pkg::OFFSET_RESET;
		end else if (wr_lo) begin
			lo_r <= wdata & cpr_pkg::LO_BYTE_MASK;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hi_r <= cpr_pkg::OFFSET_RESET;
		end else if (clear) begin
			hi_r <= cpr_pkg::OFFSET_RESET;
		end else if (wr_hi) begin
			hi_r <= wdata;
		end
	end

	assign offset = {hi_r, lo_r};

endmodule : cpr_io_offset

/* File: src/cpr_pkg.sv */
// Shared constants for the socket offset and card-detect register bank
package cpr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register port geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int OFFSET_W = 16;
	localparam int NUM_WIN = 2;

	////////////////////////////////////////////////////////////////////////////
	// Socket offsets
	localparam logic [ADDR_W-1:0] OFS_CARD_DETECT = 12'h816;
	localparam logic [ADDR_W-1:0] OFS_WIN0_LO = 12'h836;
	localparam logic [ADDR_W-1:0] OFS_WIN0_HI = 12'h837;
	localparam logic [ADDR_W-1:0] OFS_WIN1_LO = 12'h838;
	localparam logic [ADDR_W-1:0] OFS_WIN1_HI = 12'h839;

	////////////////////////////////////////////////////////////////////////////
	// Card-detect register fields
	localparam int BIT_SENSE2 = 7;
	localparam int BIT_SENSE1 = 6;
	localparam int BIT_SOFT_IRQ = 5;
	localparam int BIT_WAKE_EN = 4;
	localparam int BIT_REMOVAL_RST = 1;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and fixed bits
	localparam logic [DATA_W-1:0] OFFSET_RESET = 8'h00;
	localparam logic [DATA_W-1:0] LO_BYTE_MASK = 8'hfe;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

endpackage : cpr_pkg

/* File: src/cpr_regs.sv */
// Socket I/O offset registers and card-detect/general-control register
//
// Overview of operation
// - Offset low byte bit 0 reads zero
// - Low byte holds offset bits 7..0
// - High byte holds offset bits 15..8
// - Window 0 bytes at 836h and 837h
// - Window 1 bytes at 838h and 839h
// - Card-detect register sits at 816h
// - Bit 7 shows second sense pin level
// - Bit 6 shows first sense pin level
// - Writing bit 5 raises detect interrupt
// - Bit 5 write ignored when interrupt disabled
// - Bit 5 always reads zero
// - Detect change with resume pulls ring low
// - Ring stays low until change flag cleared
// - Bit 1 resets registers on removal
// - Bits 3, 2, 0 read zero
module cpr_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Byte register port
	input wire logic [cpr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [cpr_pkg::DATA_W-1:0] reg_wdata,
	output logic [cpr_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rd_ack,
	// Socket pins
	input wire logic voltage_sense_1,
	input wire logic voltage_sense_2,
	input wire logic card_present_in_a_n,
	input wire logic card_present_in_b_n,
	// Status-change logic alongside
	input wire logic detect_irq_enable,
	input wire logic card_change_flag,
	output logic soft_detect_irq,
	output logic removal_reg_reset,
	output logic ring_wake_out_n,
	// Window offsets to the decoder
	output logic [cpr_pkg::OFFSET_W-1:0] io_win0_offset,
	output logic [cpr_pkg::OFFSET_W-1:0] io_win1_offset
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic hit(input logic [cpr_pkg::ADDR_W-1:0] a,
			input logic [cpr_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	localparam logic [cpr_pkg::NUM_WIN-1:0][cpr_pkg::ADDR_W-1:0] WIN_LO_OFS =
		{cpr_pkg::OFS_WIN1_LO, cpr_pkg::OFS_WIN0_LO};
	localparam logic [cpr_pkg::NUM_WIN-1:0][cpr_pkg::ADDR_W-1:0] WIN_HI_OFS =
		{cpr_pkg::OFS_WIN1_HI, cpr_pkg::OFS_WIN0_HI};

	logic wr_cd;
	assign wr_cd = reg_wr && hit(reg_addr, cpr_pkg::OFS_CARD_DETECT);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] sense_lvl;
	logic [1:0] cd_lvl;

	cpr_sync #(.WIDTH(2)) u_sense_sync (
		.clk(clk),
		.resetn(resetn),
		.pin({voltage_sense_2, voltage_sense_1}),
		.level(sense_lvl)
	);

	cpr_sync #(.WIDTH(2)) u_cd_sync (
		.clk(clk),
		.resetn(resetn),
		.pin({card_present_in_b_n, card_present_in_a_n}),
		.level(cd_lvl)
	);

	////////////////////////////////////////////////////////////////////////////
	// Card-detect change and removal

	// Synchroniser fill plus one history sample
	localparam int PRIME_LEN = 3;

	logic [1:0] cd_prev_r;
	logic [PRIME_LEN-1:0] primed_r;
	logic cd_change;
	logic removal;

	// The synchroniser shows its reset value, not the pins, for two cycles
	// after release; comparing before it has filled would see a false change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cd_prev_r <= 2'h0;
			primed_r <= '0;
		end else begin
			cd_prev_r <= cd_lvl;
			primed_r <= {primed_r[PRIME_LEN-2:0], 1'b1};
		end
	end

	assign cd_change = primed_r[PRIME_LEN-1] && (cd_lvl != cd_prev_r);
	assign removal = primed_r[PRIME_LEN-1] && (cd_prev_r == 2'h0) && (cd_lvl != 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// Control bits

	logic wake_en_r;
	logic removal_rst_en_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wake_en_r <= 1'b0;
			removal_rst_en_r <= 1'b0;
		end else if (wr_cd) begin
			wake_en_r <= reg_wdata[cpr_pkg::BIT_WAKE_EN];
			removal_rst_en_r <= reg_wdata[cpr_pkg::BIT_REMOVAL_RST];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software detect interrupt, a pulse never stored

	logic soft_irq_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			soft_irq_r <= 1'b0;
		end else begin
			soft_irq_r <= wr_cd && reg_wdata[cpr_pkg::BIT_SOFT_IRQ]
				&& detect_irq_enable;
		end
	end

	assign soft_detect_irq = soft_irq_r;

	////////////////////////////////////////////////////////////////////////////
	// Removal reset

	logic removal_rst_r;
	logic clear_win;

	assign clear_win = removal && removal_rst_en_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			removal_rst_r <= 1'b0;
		end else begin
			removal_rst_r <= clear_win;
		end
	end

	assign removal_reg_reset = removal_rst_r;

	////////////////////////////////////////////////////////////////////////////
	// Ring wake output

	logic ring_n_r;
	logic flag_seen_r;
	logic ring_set;
	logic ring_clr;

	// The change flag may rise some cycles after the detect change, so the
	// ring is released only once the flag has been seen high and then low
	assign ring_set = wake_en_r && cd_change;
	assign ring_clr = flag_seen_r && !card_change_flag;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ring_n_r <= 1'b1;
		end else if (ring_set) begin
			ring_n_r <= 1'b0;
		end else if (ring_clr) begin
			ring_n_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_seen_r <= 1'b0;
		end else if (ring_set || ring_n_r) begin
			flag_seen_r <= 1'b0;
		end else if (card_change_flag) begin
			flag_seen_r <= 1'b1;
		end
	end

	assign ring_wake_out_n = ring_n_r;

	////////////////////////////////////////////////////////////////////////////
	// I/O window offsets

	logic [cpr_pkg::NUM_WIN-1:0][cpr_pkg::OFFSET_W-1:0] win_off;

	generate
		for (genvar w = 0; w < cpr_pkg::NUM_WIN; w++) begin : g_win
			cpr_io_offset u_off (
				.clk(clk),
				.resetn(resetn),
				.clear(clear_win),
				.wr_lo(reg_wr && hit(reg_addr, WIN_LO_OFS[w])),
				.wr_hi(reg_wr && hit(reg_addr, WIN_HI_OFS[w])),
				.wdata(reg_wdata),
				.offset(win_off[w])
			);
		end
	endgenerate

	assign io_win0_offset = win_off[0];
	assign io_win1_offset = win_off[1];

	////////////////////////////////////////////////////////////////////////////
	// Read path, one cycle after the strobe

	logic [cpr_pkg::DATA_W-1:0] rd_mux;
	logic [cpr_pkg::DATA_W-1:0] rdata_r;
	logic rd_ack_r;

	always_comb begin
		rd_mux = cpr_pkg::RDATA_IDLE;
		if (hit(reg_addr, cpr_pkg::OFS_CARD_DETECT)) begin
			rd_mux[cpr_pkg::BIT_SENSE2] = sense_lvl[1];
			rd_mux[cpr_pkg::BIT_SENSE1] = sense_lvl[0];
			rd_mux[cpr_pkg::BIT_WAKE_EN] = wake_en_r;
			rd_mux[cpr_pkg::BIT_REMOVAL_RST] = removal_rst_en_r;
		end
		for (int w = 0; w < cpr_pkg::NUM_WIN; w++) begin
			if (hit(reg_addr, WIN_LO_OFS[w])) begin
				rd_mux = win_off[w][7:0];
			end
			if (hit(reg_addr, WIN_HI_OFS[w])) begin
				rd_mux = win_off[w][15:8];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= cpr_pkg::RDATA_IDLE;
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= reg_rd;
			if (reg_rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rd_ack = rd_ack_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_wr_cd_soft;
		reg_wr && reg_addr == cpr_pkg::OFS_CARD_DETECT && reg_wdata[5];
	endsequence

	sequence s_wake_armed_change;
		wake_en_r ##0 cd_change;
	endsequence

	sequence s_rd_cd;
		reg_rd && reg_addr == cpr_pkg::OFS_CARD_DETECT;
	endsequence

	low_bit_zero_a: assert property (!io_win0_offset[0] && !io_win1_offset[0])
		else $error("Offset low byte bit 0 is set");

	lo_write_a: assert property (reg_wr && reg_addr == cpr_pkg::OFS_WIN0_LO && !clear_win
			|=> io_win0_offset[7:1] == $past(reg_wdata[7:1]))
		else $error("Window 0 low byte did not take the write");

	hi_write_a: assert property (reg_wr && reg_addr == cpr_pkg::OFS_WIN1_HI && !clear_win
			|=> io_win1_offset[15:8] == $past(reg_wdata))
		else $error("Window 1 high byte did not take the write");

	win0_hi_write_a: assert property (reg_wr && reg_addr == cpr_pkg::OFS_WIN0_HI && !clear_win
			|=> io_win0_offset[15:8] == $past(reg_wdata))
		else $error("Window 0 high byte did not take the write");

	sense_read_a: assert property (s_rd_cd
			|=> reg_rd_ack && reg_rdata[7:6] == $past(sense_lvl))
		else $error("Sense levels misreported");

	rsvd_read_a: assert property (s_rd_cd
			|=> reg_rdata[5] == 1'b0 && reg_rdata[3:2] == 2'h0 && !reg_rdata[0])
		else $error("Reserved or trigger bit read nonzero");

	soft_irq_a: assert property (s_wr_cd_soft ##0 detect_irq_enable
			|=> soft_detect_irq ##1 (!soft_detect_irq || $past(wr_cd
			&& reg_wdata[cpr_pkg::BIT_SOFT_IRQ] && detect_irq_enable)))
		else $error("Software detect interrupt not one pulse");

	soft_gate_a: assert property (soft_detect_irq
			|-> $past(detect_irq_enable) && $past(reg_wr))
		else $error("Software interrupt raised while disabled");

	ring_fall_a: assert property (s_wake_armed_change |=> !ring_wake_out_n)
		else $error("Ring wake not asserted on detect change");

	ring_hold_a: assert property (!ring_wake_out_n && !ring_clr
			|=> !ring_wake_out_n)
		else $error("Ring wake released before flag cleared");

	ring_off_a: assert property (ring_wake_out_n && !wake_en_r
			|=> ring_wake_out_n)
		else $error("Ring wake driven while resume disabled");

	removal_clear_a: assert property (removal && removal_rst_en_r
			|=> io_win0_offset == 16'h0000 && io_win1_offset == 16'h0000
			&& removal_reg_reset)
		else $error("Removal reset did not clear offsets");

endmodule : cpr_regs

/* File: src/cpr_sync.sv */
// Two-flop synchroniser for socket pins
module cpr_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] level_r;

	// Only level_r reads meta_r
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			level_r <= '0;
		end else begin
			meta_r <= pin;
			level_r <= meta_r;
		end
	end

	assign level = level_r;

endmodule : cpr_sync

/* File: test/test_cpr_regs.sv */
// Self-checking bench for the socket offset and card-detect registers
module test_cpr_regs;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rd_ack;
	logic voltage_sense_1 = 1'b0;
	logic voltage_sense_2 = 1'b0;
	logic card_present_in_a_n = 1'b0;
	logic card_present_in_b_n = 1'b0;
	logic detect_irq_enable = 1'b0;
	logic card_change_flag = 1'b0;
	logic soft_detect_irq;
	logic removal_reg_reset;
	logic ring_wake_out_n;
	logic [15:0] io_win0_offset;
	logic [15:0] io_win1_offset;
	int seed = 8830;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] m_off [2] = '{16'h0000, 16'h0000};
	logic m_wake = 1'b0;
	logic m_rm = 1'b0;
	logic [11:0] a;
	logic [7:0] d;
	logic [11:0] addrs [6] = '{cpr_pkg::OFS_CARD_DETECT, cpr_pkg::OFS_WIN0_LO,
		cpr_pkg::OFS_WIN0_HI, cpr_pkg::OFS_WIN1_LO, cpr_pkg::OFS_WIN1_HI, 12'h835};

	cpr_regs cpr_regs_inst (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .reg_rd_ack, .voltage_sense_1, .voltage_sense_2, .card_present_in_a_n,
		.card_present_in_b_n, .detect_irq_enable, .card_change_flag, .soft_detect_irq,
		.removal_reg_reset, .ring_wake_out_n, .io_win0_offset, .io_win1_offset);

	always #2 clk = ~clk;

	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			mismatches++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] r8();
		return 8'($random(seed));
	endfunction : r8

	function automatic logic [7:0] exp_rd(input logic [11:0] ad);
		case (ad)
			cpr_pkg::OFS_WIN0_LO: return m_off[0][7:0];
			cpr_pkg::OFS_WIN0_HI: return m_off[0][15:8];
			cpr_pkg::OFS_WIN1_LO: return m_off[1][7:0];
			cpr_pkg::OFS_WIN1_HI: return m_off[1][15:8];
			cpr_pkg::OFS_CARD_DETECT:
				return {voltage_sense_2, voltage_sense_1, 1'b0, m_wake, 2'b00, m_rm, 1'b0};
			default: return 8'h00;
		endcase
	endfunction : exp_rd

	task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk_val

	task automatic chk_pin(input string what, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask : chk_pin

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Each access leaves one idle cycle so a strobe is never lowered and raised at once
	task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
		logic exp_irq;
		reg_addr = ad;
		reg_wdata = dt;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		if (ad == cpr_pkg::OFS_WIN0_LO) m_off[0][7:0] = dt & 8'hfe;
		if (ad == cpr_pkg::OFS_WIN0_HI) m_off[0][15:8] = dt;
		if (ad == cpr_pkg::OFS_WIN1_LO) m_off[1][7:0] = dt & 8'hfe;
		if (ad == cpr_pkg::OFS_WIN1_HI) m_off[1][15:8] = dt;
		if (ad == cpr_pkg::OFS_CARD_DETECT) begin
			m_wake = dt[4];
			m_rm = dt[1];
		end
		exp_irq = ad == cpr_pkg::OFS_CARD_DETECT && dt[5] && detect_irq_enable;
		chk_pin("soft_detect_irq", exp_irq, soft_detect_irq);
		chk_val("io_win0_offset", m_off[0], io_win0_offset);
		chk_val("io_win1_offset", m_off[1], io_win1_offset);
		step(1);
		chk_pin("soft_detect_irq", 1'b0, soft_detect_irq);
	endtask : wr

	task automatic rd(input logic [11:0] ad);
		reg_addr = ad;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		chk_pin("reg_rd_ack", 1'b1, reg_rd_ack);
		chk_val("reg_rdata", {8'h00, exp_rd(ad)}, {8'h00, reg_rdata});
		step(1);
		chk_pin("reg_rd_ack", 1'b0, reg_rd_ack);
	endtask : rd

	task automatic wait_ring(input logic lvl);
		int k;
		k = 0;
		while (ring_wake_out_n !== lvl && k < 8) begin
			step(1);
			k++;
		end
		chk_pin("ring_wake_out_n", lvl, ring_wake_out_n);
	endtask : wait_ring

	task automatic count_rm(input int e);
		int n;
		n = 0;
		repeat (8) begin
			step(1);
			if (removal_reg_reset === 1'b1) n++;
		end
		chk_val("removal_reg_reset pulses", e[15:0], n[15:0]);
	endtask : count_rm

	task automatic complete_run;
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////
	initial begin
		{voltage_sense_2, voltage_sense_1} = 2'(r8());
		step(4);
		resetn = 1'b1;
		step(3);
		foreach (addrs[i]) rd(addrs[i]);
		for (int i = 0; i < 40; i++) begin
			a = addrs[r8() % 8'h06];
			detect_irq_enable = r8() > 8'h7f;
			{voltage_sense_2, voltage_sense_1} = 2'(r8());
			d = r8();
			wr(a, d);
			step(2);
			rd(a);
		end
		detect_irq_enable = 1'b1;
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h20);
		detect_irq_enable = 1'b0;
		wr(cpr_pkg::OFS_CARD_DETECT, 8'hff);
		rd(cpr_pkg::OFS_CARD_DETECT);
		// Wake path: a flag low that was never high must not release the ring
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h10);
		card_present_in_b_n = 1'b1;
		wait_ring(1'b0);
		step(3);
		chk_pin("ring_wake_out_n", 1'b0, ring_wake_out_n);
		card_change_flag = 1'b1;
		step(2);
		chk_pin("ring_wake_out_n", 1'b0, ring_wake_out_n);
		card_change_flag = 1'b0;
		wait_ring(1'b1);
		card_present_in_b_n = 1'b0;
		wait_ring(1'b0);
		card_change_flag = 1'b1;
		step(1);
		card_change_flag = 1'b0;
		wait_ring(1'b1);
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h00);
		card_present_in_b_n = 1'b1;
		step(8);
		chk_pin("ring_wake_out_n", 1'b1, ring_wake_out_n);
		card_present_in_b_n = 1'b0;
		step(4);
		// Removal with and without the register reset enabled
		wr(cpr_pkg::OFS_WIN0_HI, 8'h5a);
		wr(cpr_pkg::OFS_WIN1_LO, 8'hc3);
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h02);
		card_present_in_a_n = 1'b1;
		count_rm(1);
		m_off[0] = 16'h0000;
		m_off[1] = 16'h0000;
		chk_val("io_win0_offset", m_off[0], io_win0_offset);
		rd(cpr_pkg::OFS_WIN1_LO);
		card_present_in_a_n = 1'b0;
		step(4);
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h00);
		wr(cpr_pkg::OFS_WIN0_HI, 8'h5a);
		card_present_in_a_n = 1'b1;
		count_rm(0);
		rd(cpr_pkg::OFS_WIN0_HI);
		// Reset in mid-run
		resetn = 1'b0;
		step(2);
		m_off[0] = 16'h0000;
		m_off[1] = 16'h0000;
		m_wake = 1'b0;
		m_rm = 1'b0;
		chk_val("io_win0_offset", m_off[0], io_win0_offset);
		chk_pin("ring_wake_out_n", 1'b1, ring_wake_out_n);
		resetn = 1'b1;
		// Card stays out across reset: enables set at once must see no false change
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h12);
		count_rm(0);
		chk_pin("ring_wake_out_n", 1'b1, ring_wake_out_n);
		wr(cpr_pkg::OFS_CARD_DETECT, 8'h00);
		rd(cpr_pkg::OFS_WIN0_HI);
		complete_run();
	end
endmodule : test_cpr_regs
